// *** verilog/pvm_vendor_regs.sv ***
// Vendor mode registers reached over the serial management interface.
`timescale 1ns/1ps
module pvm_vendor_regs
    import pvm_pkg::*;
(
    input wire logic mclk, // system clock, 25 MHz
    input wire logic rstn, // async reset, active low
    input wire logic mdc, // management clock pin
    input wire logic mdio_i, // management data pin, input side
    output logic mdio_o, // management data pin, output side
    output logic mdio_oe, // high while this block drives data
    input wire logic [4:0] strap_station_address, // address straps
    input wire logic [4:0] strap_operating_mode, // mode straps
    input wire logic mac_clock_slow_indicator, // MAC clock is 25MHz
    input wire logic auto_crossover_off, // crossover disable bit
    input wire logic auto_pair_a_crossed, // automatic pair A result
    input wire logic auto_pair_b_crossed, // automatic pair B result
    input wire pvm_pd_req_t pd_req, // parallel detect inputs
    input wire logic adv_wr_en, // advanced word write strobe
    input wire logic [6:0] adv_wr_addr, // advanced word index
    input wire logic [15:0] adv_wr_data, // advanced word value
    output pvm_ctrl_t ctrl // registered control outputs
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic mdc_s1;
        logic mdc_s2;
        logic mdc_s3;
        logic mdio_s1;
        logic mdio_s2;
        pvm_mdio_st_t st;
        logic [5:0] cnt;
        logic [12:0] hdr_sh;
        logic op_rd;
        logic [15:0] wr_sh;
        logic [15:0] rd_sh;
        logic mdio_o;
        logic mdio_oe;
        logic early_rxdv;
        logic lb_off;
        logic crc_tx;
        logic mac_slow;
        logic [4:0] sta_addr;
        logic [4:0] mode;
        logic [1:0] fifo;
        logic [1:0] led;
        logic rsvd_one;
        logic pair_a;
        logic pair_b;
        logic cond_pd;
        logic [7:0] ap_rsvd;
        logic [6:0] ap_addr;
        logic adv_pend1;
        logic adv_pend2;
        logic [15:0] adv_data;
        pvm_ctrl_t ctrl;
    } pvm_reg_st_t;

    pvm_reg_st_t q;
    pvm_reg_st_t d;

    logic strap_load;
    logic [9:0] strap_value;
    logic [15:0] mem_rd_data;
    logic mdc_rise;
    logic mdc_fall;
    logic bit_in;
    logic [12:0] hdr_next;
    logic [15:0] wr_word;
    logic wr_fire;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic reg_mapped(input logic [4:0] idx);
        reg_mapped = (idx >= REG_SPECIAL_MODES) && (idx <= REG_ADV_DATA);
    endfunction : reg_mapped

    function automatic logic [15:0] read_word(
        input logic [4:0] idx,
        input pvm_reg_st_t s
    );
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            REG_SPECIAL_MODES: begin
                w[SM_EARLY_RXDV_BIT] = s.early_rxdv;
                w[SM_LOOPBACK_OFF_BIT] = s.lb_off;
                w[SM_CRC_SRC_BIT] = s.crc_tx;
                w[SM_MAC_CLK_BIT] = s.mac_slow;
                w[SM_ADDR_LSB +: 5] = s.sta_addr;
            end
            REG_EXT_MODE: begin
                w[EM_MODE_LSB +: 5] = s.mode;
                w[EM_FIFO_LSB +: 2] = s.fifo;
                w[EM_LED_LSB +: 2] = s.led;
                w[EM_RSVD_ONE_BIT] = s.rsvd_one;
                w[EM_PAIR_A_BIT] = s.pair_a;
                w[EM_PAIR_B_BIT] = s.pair_b;
                w[EM_COND_PD_BIT] = s.cond_pd;
            end
            REG_ADV_ADDR: begin
                // The read bit clears itself, so it always reads zero.
                w[AP_RSVD_LSB +: 8] = s.ap_rsvd;
                w[AP_ADDR_LSB +: 7] = s.ap_addr;
            end
            REG_ADV_DATA: begin
                w = s.adv_data;
            end
            default: begin
                w = 16'h0000;
            end
        endcase
        read_word = w;
    endfunction : read_word

    // ------------------------------------------------------------
    // Helpers on the synchronised pins
    // ------------------------------------------------------------
    assign mdc_rise = q.mdc_s2 & ~q.mdc_s3;
    assign mdc_fall = ~q.mdc_s2 & q.mdc_s3;
    assign bit_in = q.mdio_s2;
    assign hdr_next = {q.hdr_sh[11:0], bit_in};
    assign wr_word = {q.wr_sh[14:0], bit_in};
    assign wr_fire = mdc_rise && (q.st == PVM_DATA) && !q.op_rd
        && (q.cnt == DATA_LAST);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.mdc_s1 = mdc;
        d.mdc_s2 = q.mdc_s1;
        d.mdc_s3 = q.mdc_s2;
        d.mdio_s1 = mdio_i;
        d.mdio_s2 = q.mdio_s1;
        d.mac_slow = mac_clock_slow_indicator;
        d.adv_pend2 = q.adv_pend1;
        d.adv_pend1 = 1'b0;

        // Frame sampling on the rising management clock edge.
        if (mdc_rise) begin
            case (q.st)
                PVM_PRE: begin
                    if (bit_in) begin
                        if (q.cnt != PREAMBLE_ONES) begin
                            d.cnt = q.cnt + 6'h01;
                        end
                    end else if (q.cnt == PREAMBLE_ONES) begin
                        d.st = PVM_HDR;
                        d.cnt = 6'h00;
                    end else begin
                        d.cnt = 6'h00;
                    end
                end
                PVM_HDR: begin
                    d.hdr_sh = hdr_next;
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == HDR_LAST) begin
                        d.cnt = 6'h00;
                        d.op_rd = (hdr_next[11:10] == OP_READ);
                        d.rd_sh = read_word(hdr_next[4:0], q);
                        // Only frames for our station and our words.
                        if (hdr_next[12]
                            && (hdr_next[9:5] == q.sta_addr)
                            && reg_mapped(hdr_next[4:0])
                            && ((hdr_next[11:10] == OP_READ)
                                || (hdr_next[11:10] == OP_WRITE))) begin
                            d.st = PVM_TA;
                        end else begin
                            d.st = PVM_PRE;
                        end
                    end
                end
                PVM_TA: begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == TA_LAST) begin
                        d.st = PVM_DATA;
                        d.cnt = 6'h00;
                    end
                end
                PVM_DATA: begin
                    d.cnt = q.cnt + 6'h01;
                    if (!q.op_rd) begin
                        d.wr_sh = wr_word;
                    end
                    if (q.cnt == DATA_LAST) begin
                        d.st = PVM_PRE;
                        d.cnt = 6'h00;
                    end
                end
                default: begin
                    d.st = PVM_PRE;
                    d.cnt = 6'h00;
                end
            endcase
        end

        // Data leaves on the falling edge so it is stable at the rise.
        if (mdc_fall) begin
            case (q.st)
                PVM_TA: begin
                    if (q.op_rd && (q.cnt == TA_LAST)) begin
                        d.mdio_oe = 1'b1;
                        d.mdio_o = 1'b0;
                    end
                end
                PVM_DATA: begin
                    if (q.op_rd) begin
                        d.mdio_oe = 1'b1;
                        d.mdio_o = q.rd_sh[15];
                        d.rd_sh = {q.rd_sh[14:0], 1'b0};
                    end
                end
                default: begin
                    d.mdio_oe = 1'b0;
                    d.mdio_o = 1'b0;
                end
            endcase
        end

        // Straps arrive once, just after reset, before any frame.
        if (strap_load) begin
            d.sta_addr = strap_value[4:0];
            d.mode = strap_value[9:5];
        end

        // Register writes; read-only bits are simply not taken.
        if (wr_fire) begin
            case (q.hdr_sh[4:0])
                REG_SPECIAL_MODES: begin
                    d.early_rxdv = wr_word[SM_EARLY_RXDV_BIT];
                    d.lb_off = wr_word[SM_LOOPBACK_OFF_BIT];
                    d.crc_tx = wr_word[SM_CRC_SRC_BIT];
                    d.sta_addr = wr_word[SM_ADDR_LSB +: 5];
                end
                REG_EXT_MODE: begin
                    d.mode = wr_word[EM_MODE_LSB +: 5];
                    d.fifo = wr_word[EM_FIFO_LSB +: 2];
                    d.led = wr_word[EM_LED_LSB +: 2];
                    d.rsvd_one = wr_word[EM_RSVD_ONE_BIT];
                    d.pair_a = wr_word[EM_PAIR_A_BIT];
                    d.pair_b = wr_word[EM_PAIR_B_BIT];
                    d.cond_pd = wr_word[EM_COND_PD_BIT];
                end
                REG_ADV_ADDR: begin
                    d.ap_rsvd = wr_word[AP_RSVD_LSB +: 8];
                    d.ap_addr = wr_word[AP_ADDR_LSB +: 7];
                    d.adv_pend1 = wr_word[AP_READ_BIT];
                end
                default: begin
                    d.adv_data = q.adv_data;
                end
            endcase
        end

        // The store needs one edge to see the new index and one to
        // answer, hence the two-stage pending flag.
        if (q.adv_pend2) begin
            d.adv_data = mem_rd_data;
        end

        // Control outputs, registered.
        d.ctrl.early_rxdv_en = q.early_rxdv;
        d.ctrl.hd_loopback_off = q.lb_off;
        d.ctrl.crc_count_tx = q.crc_tx;
        d.ctrl.station_address_field = q.sta_addr;
        d.ctrl.scrambler_seed = q.sta_addr;
        d.ctrl.operating_mode_field = q.mode;
        d.ctrl.tx_fifo_depth_bytes = FIFO_BASE_BYTES
            + {1'b0, q.fifo};
        d.ctrl.indicator_pattern_select = q.led;
        // Manual selects matter only while crossover is off.
        d.ctrl.pair_a_crossed = auto_crossover_off
            ? q.pair_a : auto_pair_a_crossed;
        d.ctrl.pair_b_crossed = auto_crossover_off
            ? q.pair_b : auto_pair_b_crossed;
        d.ctrl.pd_accept_10hd = pd_req.det_10hd
            && (!q.cond_pd || pd_req.adv_10hd);
        d.ctrl.pd_accept_100hd = pd_req.det_100hd
            && (!q.cond_pd || pd_req.adv_100hd);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= PVM_PRE;
            // The management clock idles high, so no false rise follows reset.
            {q.mdc_s1, q.mdc_s2, q.mdc_s3} <= 3'h7;
            q.mac_slow <= MAC_CLK_RESET;
            q.fifo <= FIFO_RESET;
            q.led <= LED_RESET;
            q.rsvd_one <= RSVD_ONE_RESET;
            q.ap_rsvd <= AP_RSVD_RESET;
            q.ap_addr <= ADV_ADDR_RESET;
            q.adv_data <= ADV_DATA_RESET;
            q.ctrl.tx_fifo_depth_bytes <= FIFO_BASE_BYTES;
            q.ctrl.indicator_pattern_select <= LED_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    pvm_strap_capture u_straps (
        .mclk(mclk),
        .rstn(rstn),
        .strap_pins({strap_operating_mode, strap_station_address}),
        .strap_load(strap_load),
        .strap_value(strap_value)
    );

    pvm_adv_mem #(
        .DEPTH(ADV_WORDS),
        .WIDTH(16)
    ) u_adv_mem (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(adv_wr_en),
        .wr_addr(adv_wr_addr),
        .wr_data(adv_wr_data),
        .rd_addr(q.ap_addr),
        .rd_data(mem_rd_data)
    );

    assign mdio_o = q.mdio_o;
    assign mdio_oe = q.mdio_oe;
    assign ctrl = q.ctrl;

endmodule : pvm_vendor_regs

// *** shared/pvm_pkg.sv ***
// Constants and types for the vendor mode register bank.
// Operation
// - Early-valid bit 15 makes receive-valid rise before the frame delimiter.
// - Bit 14 turns off transmit loopback in 10BASE-T half duplex.
// - Bit 7 picks the gigabit CRC counter source: 0 receive, 1 transmit.
// - Read-only MAC clock bit: 0 means 125MHz, 1 means 25MHz; resets 0.
// - Station address picks the management address and seeds the scrambler.
// - Station address takes its reset value from the strap pins.
// - Five-bit operating mode field is read/write, reset value from straps.
// - FIFO depth field: 00..11 give 4..7 bytes; resets to 00.
// - Indicator pattern field: 01,10,11 pick modes 1..3; 00 reserved; resets 11.
// - With crossover off, bit 2 sets pair A straight or crossed.
// - With crossover off, bit 1 sets pair B straight or crossed.
// - Bit 0 set limits parallel detect to advertised half-duplex speeds.
// - Writing 1 to address-port bit 15 latches the chosen word; self-clears.
// - Read-back of address-port bits 14 to 7 is not to be relied on.
// - Seven-bit advanced address, valid 0 to 12, resets to zero.
// - Read data port shows the last latched word; resets to zero.
// - Crossover-off input stops automatic crossover; select bits then rule.
package pvm_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [4:0] REG_SPECIAL_MODES = 5'h12;
    localparam logic [4:0] REG_EXT_MODE = 5'h13;
    localparam logic [4:0] REG_ADV_ADDR = 5'h14;
    localparam logic [4:0] REG_ADV_DATA = 5'h15;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SM_EARLY_RXDV_BIT = 15;
    localparam int SM_LOOPBACK_OFF_BIT = 14;
    localparam int SM_CRC_SRC_BIT = 7;
    localparam int SM_MAC_CLK_BIT = 6;
    localparam int SM_ADDR_LSB = 0;
    localparam int EM_MODE_LSB = 11;
    localparam int EM_FIFO_LSB = 9;
    localparam int EM_LED_LSB = 4;
    localparam int EM_RSVD_ONE_BIT = 3;
    localparam int EM_PAIR_A_BIT = 2;
    localparam int EM_PAIR_B_BIT = 1;
    localparam int EM_COND_PD_BIT = 0;
    localparam int AP_READ_BIT = 15;
    localparam int AP_RSVD_LSB = 7;
    localparam int AP_ADDR_LSB = 0;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [1:0] LED_RESET = 2'h3;
    localparam logic [1:0] FIFO_RESET = 2'h0;
    localparam logic RSVD_ONE_RESET = 1'b1;
    localparam logic MAC_CLK_RESET = 1'b0;
    localparam logic [7:0] AP_RSVD_RESET = 8'h00;
    localparam logic [6:0] ADV_ADDR_RESET = 7'h00;
    localparam logic [15:0] ADV_DATA_RESET = 16'h0000;
    localparam logic [2:0] FIFO_BASE_BYTES = 3'h4;
    localparam int ADV_WORDS = 13;
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0c;
    localparam logic [5:0] TA_LAST = 6'h01;
    localparam logic [5:0] DATA_LAST = 6'h0f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PVM_PRE = 2'b00,
        PVM_HDR = 2'b01,
        PVM_TA = 2'b10,
        PVM_DATA = 2'b11
    } pvm_mdio_st_t;

    typedef struct packed {
        logic early_rxdv_en;
        logic hd_loopback_off;
        logic crc_count_tx;
        logic [4:0] station_address_field;
        logic [4:0] scrambler_seed;
        logic [4:0] operating_mode_field;
        logic [2:0] tx_fifo_depth_bytes;
        logic [1:0] indicator_pattern_select;
        logic pair_a_crossed;
        logic pair_b_crossed;
        logic pd_accept_10hd;
        logic pd_accept_100hd;
    } pvm_ctrl_t;

    typedef struct packed {
        logic det_10hd;
        logic det_100hd;
        logic adv_10hd;
        logic adv_100hd;
    } pvm_pd_req_t;

endpackage : pvm_pkg

// *** verilog/pvm_strap_capture.sv ***
// Strap pin synchroniser and one-shot capture after reset release.
`timescale 1ns/1ps
module pvm_strap_capture
    import pvm_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [9:0] strap_pins, // {mode, station address} straps
    output logic strap_load, // one-cycle pulse, values valid
    output logic [9:0] strap_value // captured strap levels
);
    typedef struct packed {
        logic [9:0] s1;
        logic [9:0] s2;
        logic [1:0] wait_cnt;
        logic done;
        logic load;
        logic [9:0] value;
    } pvm_strap_st_t;

    pvm_strap_st_t q;
    pvm_strap_st_t d;

    // The wait lets the synchroniser fill before the levels are taken.
    always_comb begin
        d = q;
        d.s1 = strap_pins;
        d.s2 = q.s1;
        d.load = 1'b0;
        if (!q.done) begin
            if (q.wait_cnt == STRAP_SETTLE) begin
                d.done = 1'b1;
                d.load = 1'b1;
                d.value = q.s2;
            end else begin
                d.wait_cnt = q.wait_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign strap_load = q.load;
    assign strap_value = q.value;

endmodule : pvm_strap_capture

// *** verilog/pvm_adv_mem.sv ***
// Small advanced register store with a registered read port.
`timescale 1ns/1ps
module pvm_adv_mem
    import pvm_pkg::*;
#(
    parameter int DEPTH = ADV_WORDS,
    parameter int WIDTH = 16
) (
    input wire logic mclk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic wr_en, // write strobe from the datapath
    input wire logic [6:0] wr_addr, // write word index
    input wire logic [WIDTH-1:0] wr_data, // write word
    input wire logic [6:0] rd_addr, // read word index
    output logic [WIDTH-1:0] rd_data // registered read word
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } pvm_mem_st_t;

    pvm_mem_st_t q;
    pvm_mem_st_t d;

    // Indices past the last word read as zero and drop writes.
    always_comb begin
        d = q;
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            d.mem[wr_addr] = wr_data;
        end
        if (int'(rd_addr) < DEPTH) begin
            d.rd = q.mem[rd_addr];
        end else begin
            d.rd = '0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd;

endmodule : pvm_adv_mem

// *** bench/pvm_vendor_regs_asserts.sv ***
// Port-level checks for the vendor mode register bank.
`timescale 1ns/1ps
module pvm_vendor_regs_asserts
    import pvm_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic mdio_o, // management data out
    input wire logic mdio_oe, // management drive enable
    input wire logic [4:0] strap_station_address, // address straps
    input wire logic [4:0] strap_operating_mode, // mode straps
    input wire logic auto_crossover_off, // crossover disable
    input wire logic auto_pair_a_crossed, // automatic pair A result
    input wire logic auto_pair_b_crossed, // automatic pair B result
    input wire pvm_pd_req_t pd_req, // parallel detect inputs
    input wire pvm_ctrl_t ctrl // control outputs
);
    logic [3:0] age_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Age 8 is safely after the strap load.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end
    property p_seed;
        ctrl.scrambler_seed == ctrl.station_address_field;
    endproperty
    a_seed: assert property (p_seed) else $error("seed off");
    property p_strap_addr;
        age_q == 4'h8 |-> ctrl.station_address_field == strap_station_address;
    endproperty
    a_strap_addr: assert property (p_strap_addr) else $error("addr");
    property p_strap_mode;
        age_q == 4'h8 |-> ctrl.operating_mode_field == strap_operating_mode;
    endproperty
    a_strap_mode: assert property (p_strap_mode) else $error("mode");
    property p_pair_a;
        !auto_crossover_off |=> ctrl.pair_a_crossed == $past(auto_pair_a_crossed);
    endproperty
    a_pair_a: assert property (p_pair_a) else $error("pair a");
    property p_pair_b;
        !auto_crossover_off |=> ctrl.pair_b_crossed == $past(auto_pair_b_crossed);
    endproperty
    a_pair_b: assert property (p_pair_b) else $error("pair b");
    property p_pd10;
        !pd_req.det_10hd |=> !ctrl.pd_accept_10hd;
    endproperty
    a_pd10: assert property (p_pd10) else $error("pd 10");
    property p_pd100;
        !pd_req.det_100hd |=> !ctrl.pd_accept_100hd;
    endproperty
    a_pd100: assert property (p_pd100) else $error("pd 100");
    property p_answer;
        $rose(mdio_oe) |-> !mdio_o ##0 mdio_oe[*8];
    endproperty
    a_answer: assert property (p_answer) else $error("answer");
    c_read: cover property ($rose(mdio_oe));
    c_early: cover property ($rose(ctrl.early_rxdv_en));
    c_pd: cover property ($rose(ctrl.pd_accept_10hd));
endmodule : pvm_vendor_regs_asserts
bind pvm_vendor_regs pvm_vendor_regs_asserts chk (.*);

// *** bench/pvm_smc_model.sv ***
// Station management controller model for the management pins.
`timescale 1ns/1ps
module pvm_smc_model
    import pvm_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic mdio_w, // resolved management data wire
    output logic mdc, // management clock, still between frames
    output logic mdio_h, // host data
    output logic mdio_en // high while the host drives data
);
    initial begin
        {mdc, mdio_h, mdio_en} = 3'h2;
    end
    // One bit per ten mclk; data moves with mdc low, sampled at the rise.
    task automatic send(input logic en, input logic b, output logic s);
        @(negedge mclk);
        mdc = 1'b0;
        mdio_en = en;
        mdio_h = en ? b : ~b;
        repeat (5) @(negedge mclk);
        mdc = 1'b1;
        s = mdio_w;
        repeat (4) @(negedge mclk);
    endtask : send
    // A released line reads high through the pull-up.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
            input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic s;
        hdr = {2'b01, op, phy, rg};
        for (int i = 0; i < 32; i++) send(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) send(1'b1, hdr[i], s);
        for (int i = 1; i >= 0; i--) send(op == OP_WRITE, i == 1, s);
        for (int i = 15; i >= 0; i--) begin
            send(op == OP_WRITE, wd[i], s);
            rd[i] = s;
        end
        send(1'b0, 1'b1, s);
    endtask : frame
endmodule : pvm_smc_model

// *** bench/pvm_vendor_regs_test.sv ***
// Self-checking bench for the vendor mode register bank.
`timescale 1ns/1ps
module pvm_vendor_regs_test
    import pvm_pkg::*;
;
    logic mclk, rstn, mdc, mdio_h, mdio_en, mdio_o, mdio_oe, mdio_w;
    logic mac_clock_slow_indicator, auto_crossover_off, adv_wr_en;
    logic auto_pair_a_crossed, auto_pair_b_crossed;
    logic [4:0] strap_station_address, strap_operating_mode, phy;
    logic [6:0] adv_wr_addr;
    logic [15:0] adv_wr_data, rd;
    pvm_pd_req_t pd_req;
    pvm_ctrl_t ctrl;
    logic [6:0] adv_idx [3] = '{7'h0d, 7'h03, 7'h0c};
    logic [15:0] adv_exp [3] = '{16'h0000, 16'h1234, 16'habcd};
    int err_total = 0;
    int total_checks = 0;
    assign mdio_w = mdio_oe ? mdio_o : (mdio_en ? mdio_h : 1'b1);
    pvm_smc_model smc (.*);
    pvm_vendor_regs DUT (.mdio_i(mdio_w), .*);
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [15:0] got,
            input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        smc.frame(OP_WRITE, phy, rg, d, rd);
    endtask : wr
    task automatic rdc(input string nm, input logic [4:0] rg,
            input logic [15:0] e);
        smc.frame(OP_READ, phy, rg, 16'h0000, rd);
        check(nm, rd, e);
    endtask : rdc
    task automatic give_verdict;
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, mac_clock_slow_indicator, auto_crossover_off, adv_wr_en} = '0;
        {auto_pair_a_crossed, auto_pair_b_crossed, pd_req} = '0;
        {adv_wr_addr, adv_wr_data} = '0;
        {strap_operating_mode, strap_station_address} = 10'h145;
        phy = 5'h05;
        repeat (10) @(negedge mclk);
        rstn = 1'b1;
        repeat (12) @(negedge mclk);
        rdc("special rst", REG_SPECIAL_MODES, 16'h0005);
        rdc("ext rst", REG_EXT_MODE, 16'h5038);
        rdc("addr rst", REG_ADV_ADDR, 16'h0000);
        rdc("data rst", REG_ADV_DATA, 16'h0000);
        wr(REG_SPECIAL_MODES, 16'hffe5);
        rdc("special rw", REG_SPECIAL_MODES, 16'hc085);
        check("modes", 16'(ctrl[26:24]), 16'h0007);
        mac_clock_slow_indicator = 1'b1;
        rdc("mac clock", REG_SPECIAL_MODES, 16'hc0c5);
        wr(REG_SPECIAL_MODES, 16'h0006);
        rdc("old address", REG_SPECIAL_MODES, 16'hffff);
        phy = 5'h06;
        rdc("new address", REG_SPECIAL_MODES, 16'h0046);
        check("seed", 16'(ctrl.scrambler_seed), 16'h0006);
        check("modes off", 16'(ctrl[26:24]), 16'h0000);
        auto_crossover_off = 1'b1;
        wr(REG_EXT_MODE, 16'hffff);
        rdc("ext rw", REG_EXT_MODE, 16'hfe3f);
        check("manual pairs", 16'(ctrl[3:2]), 16'h0003);
        {auto_crossover_off, auto_pair_a_crossed, auto_pair_b_crossed} = 3'h1;
        repeat (2) @(negedge mclk);
        check("auto pairs", 16'(ctrl[3:2]), 16'h0001);
        auto_crossover_off = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(REG_EXT_MODE, {5'h0a, 2'(i), 3'h0, 2'(i), 1'b1, i[0], i[1],
                1'b0});
            check("ext ctrl", 16'(ctrl[8:2]),
                16'({3'(4 + i), 2'(i), i[0], i[1]}));
        end
        pd_req = pvm_pd_req_t'(4'hc);
        repeat (2) @(negedge mclk);
        check("pd plain", 16'(ctrl[1:0]), 16'h0003);
        wr(REG_EXT_MODE, 16'h5039);
        check("pd none", 16'(ctrl[1:0]), 16'h0000);
        pd_req = pvm_pd_req_t'(4'hd);
        repeat (2) @(negedge mclk);
        check("pd adv", 16'(ctrl[1:0]), 16'h0001);
        {adv_wr_en, adv_wr_addr, adv_wr_data} = {1'b1, 7'h03, 16'h1234};
        @(negedge mclk);
        {adv_wr_en, adv_wr_addr, adv_wr_data} = {1'b1, 7'h0c, 16'habcd};
        @(negedge mclk);
        adv_wr_en = 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(REG_ADV_ADDR, {1'b1, 8'h03, adv_idx[i]});
            smc.frame(OP_READ, phy, REG_ADV_ADDR, 16'h0000, rd);
            check("addr port", rd & 16'h807f,
                {9'h000, adv_idx[i]});
            rdc("read data", REG_ADV_DATA, adv_exp[i]);
        end
        wr(REG_ADV_DATA, 16'h5555);
        rdc("data ro", REG_ADV_DATA, 16'habcd);
        give_verdict();
    end
endmodule : pvm_vendor_regs_test
